// >>> logic/lsb_ctrl.sv
// Screen select, scroll, blink, frame timing and refresh handshake of the display driver
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module lsb_ctrl
    import lsb_pkg::*;
#(
    parameter int unsigned DISP_TICK = DISP_TICK_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    // Glass timing and contrast
    output lsb_drive_t drive,
    output lsb_bias_t bias,
    // Interrupt
    output logic irq
);
    // Register state
    logic [7:0] displayMainConfig, next_displayMainConfig;
    logic [7:0] blinkFrameClockReg, next_blinkFrameClockReg;
    logic [7:0] biasContrastConfig, next_biasContrastConfig;
    logic autoScrollEnable, next_autoScrollEnable;
    logic frameInvertEnable, next_frameInvertEnable;
    logic [1:0] screenSelect, next_screenSelect;
    logic refresh, next_refresh;
    logic updateFinishedFlag, next_updateFinishedFlag;
    logic [1:0] irqStatus, next_irqStatus;
    logic [1:0] irqEnable, next_irqEnable;
    logic [7:0] next_regRdData;
    logic next_irq;

    // Timing state
    logic [14:0] dispCnt, next_dispCnt;
    logic [8:0] quarterCnt, next_quarterCnt;
    logic [7:0] segCnt, next_segCnt;
    logic [3:0] blinkCnt, next_blinkCnt;
    logic [3:0] scrollCnt, next_scrollCnt;
    logic blinkPhase, next_blinkPhase;
    logic [1:0] scrollScreen, next_scrollScreen;
    lsb_drive_t next_drive;
    lsb_bias_t next_bias;

    // Decoded fields
    logic enable, blinkEnable, biasThird;
    logic [1:0] muxLevel, blinkFreq;
    lsb_blink_mode_t blinkMode;
    logic [3:0] frameCode;
    logic dispTick, quarterTick, segTick, frameStart;
    logic [7:0] segDiv;
    logic [1:0] lastPhase;
    logic [3:0] blinkLast, scrollLast;

    assign enable = displayMainConfig[MAIN_EN_BIT];
    assign blinkEnable = displayMainConfig[MAIN_BLINK_BIT];
    assign biasThird = displayMainConfig[MAIN_BIAS_BIT];
    assign muxLevel = displayMainConfig[MAIN_MUX_LSB +: 2];
    assign blinkMode = lsb_blink_mode_t'(blinkFrameClockReg[CLK_MODE_LSB +: 2]);
    assign blinkFreq = blinkFrameClockReg[CLK_FREQ_LSB +: 2];
    assign frameCode = blinkFrameClockReg[CLK_FD_LSB +: 4];

    // Segment clock divisor in 2048 Hz ticks
    always_comb begin
        if (muxLevel == MUX_3X || muxLevel == MUX_4X) begin
            if (frameCode == 4'h0) begin
                segDiv = SEG_DIV_FD0_MUX;
            end else if (muxLevel == MUX_3X && frameCode <= 4'h2) begin
                segDiv = SEG_DIV_CAP;
            end else begin
                segDiv = 8'(({4'h0, frameCode} + 8'h01) << 1);
            end
        end else if (frameCode == 4'h0) begin
            segDiv = SEG_DIV_FD0_2X;
        end else begin
            segDiv = 8'(({4'h0, frameCode} + 8'h01) << 2);
        end
    end

    // Reserved multiplex code runs as 2x
    always_comb begin
        case (muxLevel)
            MUX_3X: lastPhase = 2'h2;
            MUX_4X: lastPhase = 2'h3;
            default: lastPhase = 2'h1;
        endcase
    end

    // Last quarter count of one blink half period
    always_comb begin
        if (blinkMode == BLK_2HZ) begin
            blinkLast = 4'h0;
        end else begin
            blinkLast = 4'(({2'h0, blinkFreq} << 1) + 4'h1);
        end
    end
    assign scrollLast = 4'(({2'h0, blinkFreq} << 2) + 4'h3);

    assign dispTick = enable && (dispCnt == 15'(DISP_TICK - 1));
    assign quarterTick = dispTick && (quarterCnt == 9'(QUARTER_TICKS - 10'h001));
    // A divisor cut to the count or below ends the running period on the next display tick
    assign segTick = dispTick && (segCnt >= segDiv - 8'h01);
    assign frameStart = segTick && (drive.comPhase >= lastPhase);

    // Register port next values
    always_comb begin
        next_displayMainConfig = displayMainConfig;
        next_blinkFrameClockReg = blinkFrameClockReg;
        next_biasContrastConfig = biasContrastConfig;
        next_autoScrollEnable = autoScrollEnable;
        next_frameInvertEnable = frameInvertEnable;
        next_screenSelect = screenSelect;
        next_refresh = refresh;
        next_updateFinishedFlag = updateFinishedFlag;
        next_irqStatus = irqStatus;
        next_irqEnable = irqEnable;
        next_regRdData = 8'h00;
        if (regWr) begin
            case (regAddr)
                ADDR_MAIN: next_displayMainConfig = regWrData;
                ADDR_CLK: next_blinkFrameClockReg = regWrData;
                ADDR_BIAS: next_biasContrastConfig = regWrData;
                ADDR_SCREEN: begin
                    next_autoScrollEnable = regWrData[SCR_AUTO_BIT];
                    next_frameInvertEnable = regWrData[SCR_INV_BIT];
                    next_screenSelect = regWrData[SCR_SEL_LSB +: 2];
                    next_refresh = regWrData[SCR_REFRESH_BIT];
                    if (regWrData[SCR_REFRESH_BIT]) begin
                        next_updateFinishedFlag = 1'b0;
                    end
                end
                ADDR_IRQ_CLR: next_irqStatus = irqStatus & ~regWrData[1:0];
                ADDR_IRQ_EN: next_irqEnable = regWrData[1:0];
                default: ;
            endcase
        end
        // Hardware events win over a clear in the same cycle
        if (frameStart && !refresh && !drive.useDataRegs) begin
            next_updateFinishedFlag = 1'b1;
            next_irqStatus[IRQ_UPD_BIT] = 1'b1;
        end
        if (frameStart) begin
            next_irqStatus[IRQ_FRAME_BIT] = 1'b1;
        end
        if (regRd) begin
            case (regAddr)
                ADDR_MAIN: next_regRdData = displayMainConfig;
                ADDR_CLK: next_regRdData = blinkFrameClockReg;
                ADDR_BIAS: next_regRdData = biasContrastConfig;
                ADDR_SCREEN: next_regRdData = {autoScrollEnable, frameInvertEnable, 2'h0,
                    screenSelect, updateFinishedFlag, refresh};
                ADDR_IRQ_STAT: next_regRdData = {6'h00, irqStatus};
                ADDR_IRQ_EN: next_regRdData = {6'h00, irqEnable};
                default: next_regRdData = 8'h00;
            endcase
        end
        next_irq = |(next_irqStatus & next_irqEnable);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            displayMainConfig <= MAIN_RST;
            blinkFrameClockReg <= CLK_RST;
            biasContrastConfig <= BIAS_RST;
            autoScrollEnable <= 1'b0;
            frameInvertEnable <= 1'b0;
            screenSelect <= 2'h0;
            refresh <= 1'b0;
            updateFinishedFlag <= 1'b0;
            irqStatus <= IRQ_RST;
            irqEnable <= IRQ_RST;
            regRdData <= 8'h00;
            irq <= 1'b0;
        end else begin
            displayMainConfig <= next_displayMainConfig;
            blinkFrameClockReg <= next_blinkFrameClockReg;
            biasContrastConfig <= next_biasContrastConfig;
            autoScrollEnable <= next_autoScrollEnable;
            frameInvertEnable <= next_frameInvertEnable;
            screenSelect <= next_screenSelect;
            refresh <= next_refresh;
            updateFinishedFlag <= next_updateFinishedFlag;
            irqStatus <= next_irqStatus;
            irqEnable <= next_irqEnable;
            regRdData <= next_regRdData;
            irq <= next_irq;
        end
    end

    // Time base, blink, scroll and frame next values
    always_comb begin
        next_dispCnt = dispTick ? 15'h0000 : dispCnt + 15'h0001;
        next_quarterCnt = quarterCnt;
        next_segCnt = segCnt;
        next_blinkCnt = blinkCnt;
        next_scrollCnt = scrollCnt;
        next_blinkPhase = blinkPhase;
        next_scrollScreen = scrollScreen;
        next_drive = drive;
        next_drive.frameStart = frameStart;
        if (dispTick) begin
            next_quarterCnt = quarterTick ? 9'h000 : quarterCnt + 9'h001;
            next_segCnt = segTick ? 8'h00 : segCnt + 8'h01;
        end
        if (segTick) begin
            next_drive.comPhase = frameStart ? 2'h0 : drive.comPhase + 2'h1;
        end
        if (frameStart) begin
            next_drive.frameInvert = frameInvertEnable && !drive.frameInvert;
            next_drive.useDataRegs = !refresh;
        end
        if (!frameInvertEnable) begin
            next_drive.frameInvert = 1'b0;
        end
        if (refresh) begin
            next_drive.useDataRegs = 1'b0;
        end
        if (autoScrollEnable) begin
            next_blinkCnt = 4'h0;
            next_blinkPhase = 1'b1;
            if (quarterTick) begin
                next_scrollCnt = (scrollCnt >= scrollLast) ? 4'h0 : scrollCnt + 4'h1;
                if (scrollCnt >= scrollLast) begin
                    next_scrollScreen = scrollScreen + 2'h1;
                end
            end
        end else if (blinkEnable && (blinkMode == BLK_2HZ || blinkMode == BLK_RATE)) begin
            next_scrollCnt = 4'h0;
            if (quarterTick) begin
                next_blinkCnt = (blinkCnt >= blinkLast) ? 4'h0 : blinkCnt + 4'h1;
                if (blinkCnt >= blinkLast) begin
                    next_blinkPhase = !blinkPhase;
                end
            end
        end else begin
            next_scrollCnt = 4'h0;
            next_blinkCnt = 4'h0;
            next_blinkPhase = 1'b1;
        end
        next_drive.screen = autoScrollEnable ? next_scrollScreen : screenSelect;
        if (autoScrollEnable || !blinkEnable) begin
            next_drive.displayOn = 1'b1;
        end else begin
            case (blinkMode)
                BLK_SW_OFF: next_drive.displayOn = 1'b0;
                BLK_SW_ON: next_drive.displayOn = 1'b1;
                default: next_drive.displayOn = next_blinkPhase;
            endcase
        end
        // Disabled driver parks every counter so enabling starts a clean frame
        if (!enable) begin
            next_dispCnt = 15'h0000;
            next_quarterCnt = 9'h000;
            next_segCnt = 8'h00;
            next_blinkCnt = 4'h0;
            next_scrollCnt = 4'h0;
            next_blinkPhase = 1'b1;
            next_scrollScreen = 2'h0;
            next_drive = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dispCnt <= 15'h0000;
            quarterCnt <= 9'h000;
            segCnt <= 8'h00;
            blinkCnt <= 4'h0;
            scrollCnt <= 4'h0;
            blinkPhase <= 1'b1;
            scrollScreen <= 2'h0;
            drive <= '0;
        end else begin
            dispCnt <= next_dispCnt;
            quarterCnt <= next_quarterCnt;
            segCnt <= next_segCnt;
            blinkCnt <= next_blinkCnt;
            scrollCnt <= next_scrollCnt;
            blinkPhase <= next_blinkPhase;
            scrollScreen <= next_scrollScreen;
            drive <= next_drive;
        end
    end

    // Contrast level and bias multipliers
    always_comb begin
        next_bias.level = biasContrastConfig[BIAS_LVL_LSB +: 6];
        next_bias.biasThird = biasThird;
        next_bias.vbMult = biasThird ? 2'h2 : 2'h1;
        next_bias.vcMult = biasThird ? 2'h3 : 2'h2;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bias <= '0;
        end else begin
            bias <= next_bias;
        end
    end
endmodule

// >>> logic/lsb_pkg.sv
// Constants, register map and carrier types of the display screen, blink and frame control
package lsb_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned DISP_HZ = 2048;
    localparam int unsigned DISP_TICK_CYC = CLK_HZ / DISP_HZ;
    localparam logic [9:0] QUARTER_TICKS = 10'(DISP_HZ / 4);
    localparam logic [7:0] SEG_DIV_FD0_2X = 8'h80;
    localparam logic [7:0] SEG_DIV_FD0_MUX = 8'h40;
    localparam logic [7:0] SEG_DIV_CAP = 8'h06;

    localparam logic [7:0] ADDR_MAIN = 8'h95;
    localparam logic [7:0] ADDR_CLK = 8'h96;
    localparam logic [7:0] ADDR_BIAS = 8'h9C;
    localparam logic [7:0] ADDR_SCREEN = 8'hB1;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'hC0;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'hC1;
    localparam logic [7:0] ADDR_IRQ_EN = 8'hC2;

    localparam int MAIN_EN_BIT = 7;
    localparam int MAIN_BLINK_BIT = 5;
    localparam int MAIN_BIAS_BIT = 2;
    localparam int MAIN_MUX_LSB = 0;
    localparam int CLK_MODE_LSB = 6;
    localparam int CLK_FREQ_LSB = 4;
    localparam int CLK_FD_LSB = 0;
    localparam int BIAS_LVL_LSB = 0;
    localparam int SCR_AUTO_BIT = 7;
    localparam int SCR_INV_BIT = 6;
    localparam int SCR_SEL_LSB = 2;
    localparam int SCR_FLAG_BIT = 1;
    localparam int SCR_REFRESH_BIT = 0;
    localparam int IRQ_UPD_BIT = 0;
    localparam int IRQ_FRAME_BIT = 1;

    localparam logic [7:0] MAIN_RST = 8'h01;
    localparam logic [7:0] CLK_RST = 8'h00;
    localparam logic [7:0] BIAS_RST = 8'h00;
    localparam logic [1:0] IRQ_RST = 2'h0;

    localparam logic [1:0] MUX_2X = 2'h1;
    localparam logic [1:0] MUX_3X = 2'h2;
    localparam logic [1:0] MUX_4X = 2'h3;

    typedef enum logic [1:0] {
        BLK_SW_OFF = 2'h0,
        BLK_SW_ON = 2'h1,
        BLK_2HZ = 2'h2,
        BLK_RATE = 2'h3
    } lsb_blink_mode_t;

    typedef struct packed {
        logic [1:0] comPhase;
        logic frameStart;
        logic frameInvert;
        logic displayOn;
        logic [1:0] screen;
        logic useDataRegs;
    } lsb_drive_t;

    typedef struct packed {
        logic [5:0] level;
        logic biasThird;
        logic [1:0] vbMult;
        logic [1:0] vcMult;
    } lsb_bias_t;
endpackage

// >>> sim/lsb_ctrl_properties.sv
// Concurrent checks on the display control block ports
`timescale 1ns/1ps
module lsb_ctrl_properties
    import lsb_pkg::*;
#(
    parameter int unsigned DISP_TICK = DISP_TICK_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    // Outputs
    input wire lsb_drive_t drive,
    input wire lsb_bias_t bias,
    input wire logic irq
);
    logic [7:0] shMain;
    logic [7:0] shClk;
    logic [7:0] shScr;

    // Shadow copies of the main, clock and screen registers, updated on writes
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            shMain <= MAIN_RST;
            shClk <= CLK_RST;
            shScr <= 8'h00;
        end else if (regWr) begin
            if (regAddr == ADDR_MAIN) shMain <= regWrData;
            if (regAddr == ADDR_CLK) shClk <= regWrData;
            if (regAddr == ADDR_SCREEN) shScr <= regWrData;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_quiet;
        shMain[MAIN_EN_BIT] && $stable(shMain) && $stable(shClk) && $stable(shScr);
    endsequence
    sequence s_settled;
        s_quiet [*3];
    endsequence

    property p_rd_idle;
        !$past(regRd) |-> regRdData == 8'h00;
    endproperty
    property p_bias_lvl;
        regWr && regAddr == ADDR_BIAS |-> ##2 bias.level == $past(regWrData[5:0], 2);
    endproperty
    property p_bias_mult;
        $stable(shMain) [*3] |-> bias.biasThird == shMain[MAIN_BIAS_BIT]
            && bias.vbMult == (bias.biasThird ? 2'h2 : 2'h1)
            && bias.vcMult == (bias.biasThird ? 2'h3 : 2'h2);
    endproperty
    property p_off;
        !shMain[MAIN_EN_BIT] [*2] |-> drive == '0;
    endproperty
    property p_inv_off;
        s_settled ##0 !shScr[SCR_INV_BIT] |-> !drive.frameInvert;
    endproperty
    property p_frame_pulse;
        drive.frameStart |-> drive.comPhase == 2'h0 ##1 !drive.frameStart;
    endproperty
    property p_refresh;
        (shScr[SCR_REFRESH_BIT] && $stable(shScr)) [*2] |-> !drive.useDataRegs;
    endproperty
    property p_use_frame;
        shMain[MAIN_EN_BIT] && $past(shMain[MAIN_EN_BIT], 3) && $rose(drive.useDataRegs)
            |-> drive.frameStart || $past(drive.frameStart);
    endproperty
    property p_irq_mask;
        regWr && regAddr == ADDR_IRQ_EN && regWrData[1:0] == 2'h0 |-> ##2 !irq;
    endproperty
    property p_sel;
        s_settled ##0 !shScr[SCR_AUTO_BIT] |-> drive.screen == shScr[SCR_SEL_LSB+:2];
    endproperty
    property p_blink_sw;
        s_settled ##0 (!shScr[SCR_AUTO_BIT] && !shClk[CLK_MODE_LSB+1])
            |-> drive.displayOn == (!shMain[MAIN_BLINK_BIT] || shClk[CLK_MODE_LSB]);
    endproperty
    property p_scroll_on;
        s_settled ##0 shScr[SCR_AUTO_BIT] |-> drive.displayOn;
    endproperty

    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_bias_lvl: assert property (p_bias_lvl) else $error("contrast level wrong");
    a_bias_mult: assert property (p_bias_mult) else $error("bias multipliers wrong");
    a_off: assert property (p_off) else $error("drive active while off");
    a_inv_off: assert property (p_inv_off) else $error("inverted while off");
    a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse wrong");
    a_refresh: assert property (p_refresh) else $error("data used in refresh");
    a_use_frame: assert property (p_use_frame) else $error("data use off frame");
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
    a_sel: assert property (p_sel) else $error("screen select wrong");
    a_blink_sw: assert property (p_blink_sw) else $error("forced blink wrong");
    a_scroll_on: assert property (p_scroll_on) else $error("blink not suppressed");
endmodule

bind lsb_ctrl lsb_ctrl_properties #(.DISP_TICK(DISP_TICK)) u_props (
    .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .drive(drive),
    .bias(bias), .irq(irq)
);

// >>> sim/lsb_glass_model.sv
// Behavioural glass: counts frames and inversion flips seen on the drive
`timescale 1ns/1ps
module lsb_glass_model
    import lsb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Drive from the controller
    input wire lsb_drive_t drive,
    // Observed counts
    output int unsigned frameCnt,
    output int unsigned flipCnt
);
    logic lastInv;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            frameCnt <= 0;
            flipCnt <= 0;
            lastInv <= 1'b0;
        end else begin
            if (drive.frameStart) frameCnt <= frameCnt + 1;
            if (drive.frameInvert != lastInv) flipCnt <= flipCnt + 1;
            lastInv <= drive.frameInvert;
        end
    end
endmodule

// >>> sim/lcd_screen_blink_frame_ctrl_tb_top.sv
// Self-checking bench of the display screen, blink and frame control
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module lcd_screen_blink_frame_ctrl_tb_top
    import lsb_pkg::*;
;
    localparam int TK = 4;
    localparam logic [7:0] RA [8] = '{ADDR_MAIN, ADDR_CLK, ADDR_BIAS, ADDR_SCREEN,
        ADDR_IRQ_STAT, ADDR_IRQ_CLR, ADDR_IRQ_EN, 8'h55};
    localparam logic [3:0] FDS [4] = '{4'h0, 4'h1, 4'h2, 4'hF};
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdData;
    lsb_drive_t drive;
    lsb_bias_t bias;
    logic irq;
    int unsigned frameCnt;
    int unsigned flipCnt;
    int error_cnt = 0;
    int checks = 0;
    logic [31:0] seed = 32'h2154;

    always #10 sys_clk = ~sys_clk;

    lsb_ctrl #(.DISP_TICK(TK)) DUT (.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .drive(drive), .bias(bias), .irq(irq));
    lsb_glass_model GLASS (.sys_clk(sys_clk), .rst_b(rst_b), .drive(drive),
        .frameCnt(frameCnt), .flipCnt(flipCnt));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Frame period in sys_clk cycles for a multiplex code and frame code
    function automatic int expFrame(input logic [1:0] mux, input logic [3:0] fd);
        int n;
        int div;
        n = (mux == MUX_3X) ? 3 : (mux == MUX_4X) ? 4 : 2;
        if (n == 2) div = (fd == 4'h0) ? 128 : 4 * (fd + 1);
        else if (fd == 4'h0) div = 64;
        else if (n == 3 && fd < 4'h3) div = 6;
        else div = 2 * (fd + 1);
        return div * n * TK;
    endfunction

    function automatic logic [7:0] snap(input int w);
        return (w == 0) ? frameCnt[7:0] : (w == 1) ? {7'h00, drive.displayOn} :
            {6'h00, drive.screen};
    endfunction

    task automatic conclude();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        bus(1'b0, 1'b1, a, 8'h00);
        regRd <= 1'b0;
        @(negedge sys_clk);
        q = regRdData;
        @(posedge sys_clk);
    endtask

    task automatic idle(input int n);
        regWr <= 1'b0;
        regRd <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask

    // Length of the second stretch between changes of a watched output
    task automatic gap(input int w, input int lim, output int n);
        logic [7:0] p;
        regWr <= 1'b0;
        regRd <= 1'b0;
        @(negedge sys_clk);
        for (int k = 0; k < 2; k++) begin
            p = snap(w);
            n = 0;
            while (snap(w) == p && n < lim) begin
                @(negedge sys_clk);
                n++;
            end
            if (n >= lim) begin
                error_cnt++;
                $display("[FAIL] %0t wait ran out", $time);
                conclude();
            end
        end
        @(posedge sys_clk);
    endtask

    initial begin
        logic [7:0] q;
        logic [7:0] d;
        int n;
        int unsigned f0;
        int unsigned c0;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        wr(ADDR_IRQ_STAT, 8'hFF);
        wr(8'h55, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            rd(RA[i], q);
            `CHK(q, (i == 0) ? MAIN_RST : 8'h00)
        end
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            d = seed[7:0];
            wr(ADDR_CLK, d);
            rd(ADDR_CLK, q);
            `CHK(q, d)
            wr(ADDR_BIAS, d);
            rd(ADDR_BIAS, q);
            `CHK(bias.level, d[5:0])
            wr(ADDR_SCREEN, d & 8'hCC);
            rd(ADDR_SCREEN, q);
            `CHK(q & 8'hFD, d & 8'hCC)
            wr(ADDR_MAIN, d & 8'h7F);
            rd(ADDR_MAIN, q);
            `CHK(bias.biasThird, d[MAIN_BIAS_BIT])
        end
        wr(ADDR_SCREEN, 8'h40);
        for (int m = 0; m < 4; m++) begin
            for (int j = 0; j < 4; j++) begin
                wr(ADDR_MAIN, 8'h80 | 8'(m));
                wr(ADDR_CLK, {4'h0, FDS[j]});
                gap(0, 4000, n);
                `CHK(n, expFrame(2'(m), FDS[j]))
            end
        end
        f0 = flipCnt;
        c0 = frameCnt;
        gap(0, 4000, n);
        `CHK(flipCnt - f0, frameCnt - c0)
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SCREEN, 8'(i << SCR_SEL_LSB));
            idle(4);
            `CHK(drive.screen, 2'(i))
        end
        wr(ADDR_IRQ_EN, 8'h01);
        wr(ADDR_SCREEN, 8'h01);
        idle(3);
        `CHK(drive.useDataRegs, 1'b0)
        rd(ADDR_SCREEN, q);
        `CHK(q[SCR_FLAG_BIT], 1'b0)
        wr(ADDR_IRQ_CLR, 8'h03);
        wr(ADDR_SCREEN, 8'h00);
        gap(0, 4000, n);
        `CHK(drive.useDataRegs, 1'b1)
        `CHK(irq, 1'b1)
        rd(ADDR_SCREEN, q);
        `CHK(q[SCR_FLAG_BIT], 1'b1)
        wr(ADDR_IRQ_EN, 8'h00);
        idle(2);
        `CHK(irq, 1'b0)
        wr(ADDR_IRQ_EN, 8'h01);
        wr(ADDR_IRQ_CLR, 8'h01);
        idle(2);
        `CHK(irq, 1'b0)
        wr(ADDR_MAIN, 8'hA3);
        wr(ADDR_CLK, 8'h0F);
        idle(4);
        `CHK(drive.displayOn, 1'b0)
        wr(ADDR_CLK, 8'h4F);
        idle(4);
        `CHK(drive.displayOn, 1'b1)
        wr(ADDR_CLK, 8'h8F);
        gap(1, 6000, n);
        `CHK(n, 512 * TK)
        wr(ADDR_CLK, 8'hD0);
        gap(1, 20000, n);
        `CHK(n, 4 * 512 * TK)
        wr(ADDR_CLK, 8'hC0);
        gap(1, 12000, n);
        `CHK(n, 2 * 512 * TK)
        wr(ADDR_SCREEN, 8'h80);
        gap(2, 20000, n);
        `CHK(n, 4 * 512 * TK)
        `CHK(drive.displayOn, 1'b1)
        conclude();
    end
endmodule
